// File: rfp_consts.vh
// Constants for the rail fault protection supervisor
`ifndef RFP_CONSTS_VH
`define RFP_CONSTS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define RFP_MV_W        12
`define RFP_PH_N        7
`define RFP_SEC_N       2
`define RFP_STEP_W      8
`define RFP_MASK_W      10

// ----------------------------------------
// Voltage levels in mV
// ----------------------------------------
`define RFP_OV_MARGIN   13'h00AF
`define RFP_UV_MARGIN   13'h0190
`define RFP_UV_ENABLE   12'h1F4
`define RFP_OV_RAMP     13'h0708
`define RFP_OV_OFFSET   13'h0960
`define RFP_SAFE_LEVEL  12'h0FA
`define RFP_OC_FULL     12'h9C4
`define RFP_OC_N3       12'h672
`define RFP_OC_N4       12'h4E2
`define RFP_OC_N5       12'h3E8
`define RFP_OC_N6       12'h33E
`define RFP_OC_SINGLE   12'h60E
`define RFP_IMAX_LEVEL  12'h4D8

// ----------------------------------------
// Timing
// ----------------------------------------
`define RFP_CLK_NS      4
`define RFP_MASK_NS     2000
`define RFP_MASK_CYC    ((`RFP_MASK_NS + `RFP_CLK_NS - 1) / `RFP_CLK_NS)
`define RFP_FAST_NS     50
`define RFP_FAST_CYC    ((`RFP_FAST_NS + `RFP_CLK_NS - 1) / `RFP_CLK_NS)
`define RFP_SLOW_NS     200
`define RFP_SLOW_CYC    ((`RFP_SLOW_NS + `RFP_CLK_NS - 1) / `RFP_CLK_NS)

// ----------------------------------------
// Encodings
// ----------------------------------------
`define RFP_FK_NONE     2'h0
`define RFP_FK_OV       2'h1
`define RFP_FK_UV       2'h2
`define RFP_FK_OC       2'h3
`define RFP_PS_FULL     2'h0
`define RFP_LOW_PHASES  3'h2
`define RFP_N3          3'h3
`define RFP_N4          3'h4
`define RFP_N5          3'h5
`define RFP_N6          3'h6
`define RFP_SEC_MULTI   1'h0
`define RFP_SEC_SINGLE  1'h1

`endif

// File: rfp_sync.v
// Two-stage synchroniser for asynchronous comparator levels
`include "rfp_consts.vh"

module rfp_sync #(
  parameter W = `RFP_PH_N
) (
  input  wire         clock,
  input  wire         srst,
  input  wire         clockEn,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : gBit
      reg firstQ;
      reg secondQ;
      always @(posedge clock) begin
        if (srst) begin
          firstQ  <= 1'b0;
          secondQ <= 1'b0;
        end else if (clockEn) begin
          firstQ  <= asyncIn[g];
          secondQ <= firstQ;
        end
      end
      assign syncOut[g] = secondQ;
    end
  endgenerate

endmodule // rfp_sync

// File: rfp_oc_thresh.v
// Total overcurrent threshold selection by power state and phase count
`include "rfp_consts.vh"

module rfp_oc_thresh (
  input  wire [1:0]             powerState,
  input  wire [2:0]             phaseCount,
  output wire [`RFP_MV_W-1:0]   multiOcThr
);

  function [`RFP_MV_W-1:0] scaledLevel;
    input [2:0] n;
    begin
      case (n)
        `RFP_N3: scaledLevel = `RFP_OC_N3;
        `RFP_N4: scaledLevel = `RFP_OC_N4;
        `RFP_N5: scaledLevel = `RFP_OC_N5;
        `RFP_N6: scaledLevel = `RFP_OC_N6;
        default: scaledLevel = `RFP_OC_FULL;
      endcase
    end
  endfunction

  assign multiOcThr = (powerState == `RFP_PS_FULL) ? `RFP_OC_FULL : scaledLevel(phaseCount);

endmodule // rfp_oc_thresh

// File: rfp_supervisor.v
// Fault supervisor: detection, fault latch, reference ramp and drive sequencing
`include "rfp_consts.vh"

module rfp_supervisor (
  input  wire                   clock,
  input  wire                   srst,
  input  wire                   clockEn,
  input  wire [`RFP_MV_W-1:0]   multiSectionSense,
  input  wire [`RFP_MV_W-1:0]   singleSectionSense,
  input  wire [`RFP_MV_W-1:0]   totalLimitPin,
  input  wire [`RFP_MV_W-1:0]   singleLimitPin,
  input  wire [`RFP_MV_W-1:0]   loadReportPin,
  input  wire [1:0]             voltCmdValid,
  input  wire [`RFP_MV_W-1:0]   voltCmdCode,
  input  wire                   rampFast,
  input  wire                   offsetCommanded,
  input  wire [1:0]             powerStateCommand,
  input  wire [2:0]             phaseCount,
  input  wire [6:0]             phaseCurrentOver,
  input  wire [6:0]             loopPwm,
  input  wire [6:0]             loopPwmOe,
  input  wire [1:0]             loopDriverEnable,
  input  wire [1:0]             railGood,
  output reg  [6:0]             phaseDriveOut,
  output reg  [6:0]             phaseDriveOe,
  output reg  [1:0]             driverEnableOut,
  output reg  [1:0]             railReadyFlag,
  output reg                    faultIndicatorPin,
  output reg  [1:0]             faultKind,
  output reg                    faultSection,
  output reg  [`RFP_MV_W-1:0]   multiReference,
  output reg  [`RFP_MV_W-1:0]   singleReference,
  output reg  [2:0]             activePhases,
  output reg                    maxCurrentReached
);

  // ----------------------------------------
  // Fault latch state
  // ----------------------------------------
  reg  [1:0]            kind_q;
  reg  [1:0]            kind_d;
  reg                   sect_q;
  reg                   sect_d;
  reg                   ovDone_q;
  wire                  latched = (kind_q != `RFP_FK_NONE);
  wire                  ovLatched = (kind_q == `RFP_FK_OV);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Fault flag qualified by the section it names
  function sectionHit;
    input flag;
    input sect;
    input sid;
    begin
      sectionHit = flag && (sect == sid);
    end
  endfunction

  // ----------------------------------------
  // Ramp and mask counts
  // ----------------------------------------
  // Cut to counter widths where they are used
  localparam [31:0] FAST_CYC = `RFP_FAST_CYC;
  localparam [31:0] SLOW_CYC = `RFP_SLOW_CYC;
  localparam [31:0] MASK_CYC = `RFP_MASK_CYC;

  // ----------------------------------------
  // Inputs and thresholds
  // ----------------------------------------
  wire [6:0]            phaseOcSync;
  wire [`RFP_MV_W-1:0]  multiOcThr;
  wire [2*`RFP_MV_W-1:0] senseBus = {singleSectionSense, multiSectionSense};
  wire [2*`RFP_MV_W-1:0] limitBus = {singleLimitPin, totalLimitPin};
  wire [2*`RFP_MV_W-1:0] ocThrBus = {`RFP_OC_SINGLE, multiOcThr};
  wire [2*`RFP_MV_W-1:0] refBus;
  wire [1:0]            ovHit;
  wire [1:0]            uvHit;
  wire [1:0]            ocHit;
  wire [1:0]            aboveRef;
  wire [1:0]            belowSafe;

  rfp_sync #(
    .W        (`RFP_PH_N)
  ) uSync (
    .clock    (clock),
    .srst     (srst),
    .clockEn  (clockEn),
    .asyncIn  (phaseCurrentOver),
    .syncOut  (phaseOcSync)
  );

  rfp_oc_thresh uThresh (
    .powerState (powerStateCommand),
    .phaseCount (phaseCount),
    .multiOcThr (multiOcThr)
  );

  // ----------------------------------------
  // Per-section ramp, mask and detection
  // ----------------------------------------
  genvar s;
  generate
    for (s = 0; s < `RFP_SEC_N; s = s + 1) begin : gSec
      localparam [31:0] SIDX = s;
      localparam [0:0]  SID  = SIDX[0];
      reg  [`RFP_MV_W-1:0]   ref_q;
      reg  [`RFP_MV_W-1:0]   target_q;
      reg  [`RFP_STEP_W-1:0] step_q;
      reg  [`RFP_MASK_W-1:0] mask_q;
      wire [`RFP_MV_W-1:0]   sense = senseBus[s*`RFP_MV_W +: `RFP_MV_W];
      wire [`RFP_MV_W-1:0]   limit = limitBus[s*`RFP_MV_W +: `RFP_MV_W];
      wire [`RFP_MV_W-1:0]   ocThr = ocThrBus[s*`RFP_MV_W +: `RFP_MV_W];
      wire                   ownOv = sectionHit(ovLatched, sect_q, SID);
      wire                   ramping = (ref_q != target_q);
      wire [`RFP_STEP_W-1:0] stepLimit = rampFast ? FAST_CYC[`RFP_STEP_W-1:0] :
                                         SLOW_CYC[`RFP_STEP_W-1:0];
      wire                   masked = ramping || (mask_q != {`RFP_MASK_W{1'b0}});
      wire [`RFP_MV_W:0]     ovThr;

      always @(posedge clock) begin
        if (srst) begin
          ref_q    <= {`RFP_MV_W{1'b0}};
          target_q <= {`RFP_MV_W{1'b0}};
          step_q   <= {`RFP_STEP_W{1'b0}};
          mask_q   <= {`RFP_MASK_W{1'b0}};
        end else if (clockEn) begin
          if (ownOv) begin
            target_q <= `RFP_SAFE_LEVEL;
          end else if (voltCmdValid[s] && !latched) begin
            target_q <= voltCmdCode;
          end
          if (!ramping || step_q >= stepLimit - 1'b1) begin
            step_q <= {`RFP_STEP_W{1'b0}};
          end else begin
            step_q <= step_q + 1'b1;
          end
          if (ramping && step_q >= stepLimit - 1'b1) begin
            if (ref_q < target_q) begin
              ref_q <= ref_q + 1'b1;
            end else begin
              ref_q <= ref_q - 1'b1;
            end
          end
          if (ramping) begin
            mask_q <= MASK_CYC[`RFP_MASK_W-1:0];
          end else if (mask_q != {`RFP_MASK_W{1'b0}}) begin
            mask_q <= mask_q - 1'b1;
          end
        end
      end

      assign ovThr = !masked ? ({1'b0, ref_q} + `RFP_OV_MARGIN) :
                     (offsetCommanded ? `RFP_OV_OFFSET : `RFP_OV_RAMP);
      assign ovHit[s] = ({1'b0, sense} > ovThr);
      assign uvHit[s] = !masked && (ref_q > `RFP_UV_ENABLE) &&
                        (({1'b0, sense} + `RFP_UV_MARGIN) < {1'b0, ref_q});
      assign ocHit[s] = !masked && (limit > ocThr);
      assign aboveRef[s] = (sense > ref_q);
      assign belowSafe[s] = (sense < `RFP_SAFE_LEVEL) && (ref_q == `RFP_SAFE_LEVEL);
      assign refBus[s*`RFP_MV_W +: `RFP_MV_W] = ref_q;
    end
  endgenerate

  // ----------------------------------------
  // Fault latch: first fault wins
  // ----------------------------------------
  always @* begin
    kind_d = kind_q;
    sect_d = sect_q;
    // Same cycle: excess voltage, then low voltage, then current
    // later faults ignored
    if (!latched) begin
      if (ovHit != 2'h0) begin
        kind_d = `RFP_FK_OV;
        sect_d = !ovHit[0];
      end else if (uvHit != 2'h0) begin
        kind_d = `RFP_FK_UV;
        sect_d = !uvHit[0];
      end else if (ocHit != 2'h0) begin
        kind_d = `RFP_FK_OC;
        sect_d = !ocHit[0];
      end
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      kind_q   <= `RFP_FK_NONE;
      sect_q   <= 1'b0;
      ovDone_q <= 1'b0;
    end else if (clockEn) begin
      kind_q <= kind_d;
      sect_q <= sect_d;
      if (ovLatched && belowSafe[sect_q]) begin
        ovDone_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Phase drive decisions
  // ----------------------------------------
  wire [2:0] phasesLimit;
  wire [6:0] phOut_d;
  wire [6:0] phOe_d;
  wire [1:0] drvEn_d;
  wire [1:0] ready_d;

  assign phasesLimit = ((powerStateCommand != `RFP_PS_FULL) && (phaseCount > `RFP_LOW_PHASES)) ?
                       `RFP_LOW_PHASES : phaseCount;

  genvar p;
  generate
    for (p = 0; p < `RFP_PH_N; p = p + 1) begin : gPh
      localparam [31:0] PIDX = p;
      localparam [2:0]  IDX  = PIDX[2:0];
      localparam [0:0] PSEC = (p == `RFP_PH_N - 1) ? `RFP_SEC_SINGLE : `RFP_SEC_MULTI;
      wire inUse = (PSEC == `RFP_SEC_SINGLE) || (IDX < phasesLimit);
      wire ovFollow = sectionHit(ovLatched, sect_q, PSEC) && !ovDone_q;
      // low when above ramp, else off
      assign phOe_d[p] = !latched ? (inUse && (phaseOcSync[p] || loopPwmOe[p])) :
                         (ovFollow && aboveRef[PSEC]);
      assign phOut_d[p] = (!latched && inUse && !phaseOcSync[p]) ? loopPwm[p] : 1'b0;
    end
    for (s = 0; s < `RFP_SEC_N; s = s + 1) begin : gDrv
      localparam [31:0] SIDX = s;
      localparam [0:0]  SID  = SIDX[0];
      assign drvEn_d[s] = !latched ? loopDriverEnable[s] :
                          (sectionHit(ovLatched, sect_q, SID) && !ovDone_q);
      assign ready_d[s] = railGood[s] && !sectionHit(latched, sect_q, SID);
    end
  endgenerate

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      phaseDriveOut     <= 7'h00;
      phaseDriveOe      <= 7'h00;
      driverEnableOut   <= 2'h0;
      railReadyFlag     <= 2'h0;
      faultIndicatorPin <= 1'b0;
      faultKind         <= `RFP_FK_NONE;
      faultSection      <= 1'b0;
      multiReference    <= {`RFP_MV_W{1'b0}};
      singleReference   <= {`RFP_MV_W{1'b0}};
      activePhases      <= 3'h0;
      maxCurrentReached <= 1'b0;
    end else if (clockEn) begin
      phaseDriveOut     <= phOut_d;
      phaseDriveOe      <= phOe_d;
      driverEnableOut   <= drvEn_d;
      railReadyFlag     <= ready_d;
      faultIndicatorPin <= ovLatched;
      faultKind         <= kind_q;
      faultSection      <= sect_q;
      multiReference    <= refBus[`RFP_MV_W-1:0];
      singleReference   <= refBus[2*`RFP_MV_W-1:`RFP_MV_W];
      activePhases      <= phasesLimit;
      maxCurrentReached <= (loadReportPin >= `RFP_IMAX_LEVEL);
    end
  end

endmodule // rfp_supervisor

// File: rfp_supervisor_props.sv
// Assertion checker for the rail fault protection supervisor
`include "rfp_consts.vh"
module rfp_supervisor_props (
  input logic        clock,
  input logic        srst,
  input logic [1:0]  powerStateCommand,
  input logic [6:0]  phaseCurrentOver,
  input logic [11:0] loadReportPin,
  input logic [6:0]  phaseDriveOut,
  input logic [6:0]  phaseDriveOe,
  input logic [1:0]  driverEnableOut,
  input logic [1:0]  railReadyFlag,
  input logic        faultIndicatorPin,
  input logic [1:0]  faultKind,
  input logic        faultSection,
  input logic [2:0]  activePhases,
  input logic        maxCurrentReached
);
  timeunit 1ns;
  timeprecision 1ps;
  fault_held_a: assert property (@(posedge clock) disable iff (srst)
    faultKind != `RFP_FK_NONE |=> $stable(faultKind) && $stable(faultSection))
    else $error("latched fault changed");
  fault_pin_a: assert property (@(posedge clock) disable iff (srst)
    faultIndicatorPin == (faultKind == `RFP_FK_OV))
    else $error("fault pin disagrees with fault kind");
  all_hiz_a: assert property (@(posedge clock) disable iff (srst)
    faultKind == `RFP_FK_UV || faultKind == `RFP_FK_OC |->
      phaseDriveOe == 7'h00 && driverEnableOut == 2'h0)
    else $error("switches not released on latch");
  ready_drop_a: assert property (@(posedge clock) disable iff (srst)
    faultKind != `RFP_FK_NONE |-> !railReadyFlag[faultSection])
    else $error("faulted section still ready");
  other_hiz_a: assert property (@(posedge clock) disable iff (srst)
    faultKind == `RFP_FK_OV |-> (faultSection ?
      (phaseDriveOe[5:0] == 6'h00 && !driverEnableOut[0]) :
      (!phaseDriveOe[6] && !driverEnableOut[1])))
    else $error("other section not held off");
  phase_limit_a: assert property (@(posedge clock) disable iff (srst)
    powerStateCommand != 2'h0 |=> activePhases <= `RFP_LOW_PHASES)
    else $error("too many phases in reduced state");
  max_current_a: assert property (@(posedge clock) disable iff (srst)
    1'b1 |=> maxCurrentReached == ($past(loadReportPin) >= `RFP_IMAX_LEVEL))
    else $error("maximum current flag wrong");
  phase_oc_a: assert property (@(posedge clock) disable iff (srst)
    (phaseCurrentOver[0] && faultKind == `RFP_FK_NONE && activePhases != 3'h0) [*4]
      |-> phaseDriveOe[0] && !phaseDriveOut[0])
    else $error("phase low side not held");
  reset_clear_a: assert property (@(posedge clock)
    srst |=> faultKind == `RFP_FK_NONE && !faultIndicatorPin && phaseDriveOe == 7'h00
      && railReadyFlag == 2'h0)
    else $error("reset did not clear state");
endmodule // rfp_supervisor_props

bind rfp_supervisor rfp_supervisor_props i_props (
  .clock, .srst, .powerStateCommand, .phaseCurrentOver, .loadReportPin, .phaseDriveOut,
  .phaseDriveOe, .driverEnableOut, .railReadyFlag, .faultIndicatorPin, .faultKind,
  .faultSection, .activePhases, .maxCurrentReached
);

// File: rfp_power_stage.sv
// Behavioural model of the external power stage and output rails
module rfp_power_stage (
  input  logic        clock,
  input  logic [11:0] multiReference,
  input  logic [11:0] singleReference,
  input  logic [11:0] multiOffset,
  input  logic [11:0] singleOffset,
  input  logic [6:0]  phaseDriveOut,
  input  logic [6:0]  phaseDriveOe,
  input  logic [1:0]  driverEnableOut,
  output logic [11:0] multiSense = 12'h000,
  output logic [11:0] singleSense = 12'h000,
  output logic [6:0]  lowSideOn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Low side conducts when the pin is driven low with its driver enabled
  assign lowSideOn = phaseDriveOe & ~phaseDriveOut & {driverEnableOut[1], {6{driverEnableOut[0]}}};
  // Rails settle to reference plus an injected error
  always @(posedge clock) begin
    multiSense <= multiReference + multiOffset;
    singleSense <= singleReference + singleOffset;
  end
endmodule // rfp_power_stage

// File: test_rail_fault_protection.sv
// Self-checking bench for the rail fault protection supervisor
`include "rfp_consts.vh"
module test_rail_fault_protection;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 40000;
  logic clock = 1'b0, srst = 1'b1, clockEn = 1'b1, rampFast = 1'b1, offsetCommanded = 1'b0;
  logic [11:0] totalLimitPin = 12'h000, singleLimitPin = 12'h000, loadReportPin = 12'h000;
  logic [11:0] voltCmdCode = 12'h000, mOff = 12'h000, sOff = 12'h000;
  logic [1:0]  voltCmdValid = 2'h0, powerStateCommand = 2'h0, railGood = 2'h3;
  logic [1:0]  loopDriverEnable = 2'h3;
  logic [2:0]  phaseCount = 3'h4;
  logic [6:0]  phaseCurrentOver = 7'h00, loopPwm = 7'h7F, loopPwmOe = 7'h7F;
  wire  [11:0] multiSectionSense, singleSectionSense, multiReference, singleReference;
  wire  [6:0]  phaseDriveOut, phaseDriveOe, lowSideOn;
  wire  [1:0]  driverEnableOut, railReadyFlag, faultKind;
  wire  [2:0]  activePhases;
  wire         faultIndicatorPin, faultSection, maxCurrentReached;
  int          err_count = 0, checks_done = 0, cycles = 0, k;
  logic [1:0]  tPs [5] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1};
  logic [2:0]  tN [5] = '{3'h4, 3'h3, 3'h4, 3'h5, 3'h6};
  logic [11:0] tThr [5] = '{12'h9C4, 12'h672, 12'h4E2, 12'h3E8, 12'h33E};

  rfp_supervisor i_dut (
    .clock, .srst, .clockEn, .multiSectionSense, .singleSectionSense, .totalLimitPin,
    .singleLimitPin, .loadReportPin, .voltCmdValid, .voltCmdCode, .rampFast,
    .offsetCommanded, .powerStateCommand, .phaseCount, .phaseCurrentOver, .loopPwm,
    .loopPwmOe, .loopDriverEnable, .railGood, .phaseDriveOut, .phaseDriveOe,
    .driverEnableOut, .railReadyFlag, .faultIndicatorPin, .faultKind, .faultSection,
    .multiReference, .singleReference, .activePhases, .maxCurrentReached);
  rfp_power_stage i_stage (
    .clock, .multiReference, .singleReference, .multiOffset(mOff), .singleOffset(sOff),
    .phaseDriveOut, .phaseDriveOe, .driverEnableOut, .multiSense(multiSectionSense),
    .singleSense(singleSectionSense), .lowSideOn);

  always #2 clock = ~clock;

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic rst();
    @(posedge clock);
    srst <= 1'b1;
    totalLimitPin <= 12'h000;
    loadReportPin <= 12'h000;
    mOff <= 12'h000;
    sOff <= 12'h000;
    phaseCurrentOver <= 7'h00;
    powerStateCommand <= 2'h0;
    phaseCount <= 3'h4;
    singleLimitPin <= 12'h000;
    offsetCommanded <= 1'b0;
    rampFast <= 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    cyc(3);
  endtask

  task automatic ramp(input int sec, input logic [11:0] code);
    int i;
    @(posedge clock);
    voltCmdValid <= (sec == 0) ? 2'h1 : 2'h2;
    voltCmdCode <= code;
    @(posedge clock);
    voltCmdValid <= 2'h0;
    for (i = 0; i < 20000 && (sec == 0 ? multiReference : singleReference) !== code; i++) begin
      @(posedge clock);
    end
    #1;
    chk("reference", code, sec == 0 ? multiReference : singleReference);
  endtask

  initial begin
    // ----------------------------------------
    // Excess voltage on the multi section
    // ----------------------------------------
    rst();
    ramp(0, 12'h12C);
    cyc(510);
    @(posedge clock);
    mOff <= 12'h0AF;
    cyc(8);
    chk("faultKind", `RFP_FK_NONE, faultKind);
    @(posedge clock);
    mOff <= 12'h0B0;
    cyc(5);
    chk("faultKind", `RFP_FK_OV, faultKind);
    chk("faultSection", `RFP_SEC_MULTI, faultSection);
    chk("faultIndicatorPin", 12'h001, faultIndicatorPin);
    chk("railReadyFlag", 12'h002, railReadyFlag);
    chk("lowSideOn", 12'h001, lowSideOn[0]);
    chk("otherSection", 12'h000, {phaseDriveOe[6], driverEnableOut[1]});
    @(posedge clock);
    voltCmdValid <= 2'h1;
    voltCmdCode <= 12'h258;
    @(posedge clock);
    voltCmdValid <= 2'h0;
    mOff <= 12'hFF6;
    cyc(5);
    chk("followOff", 12'h001, {phaseDriveOe[0], driverEnableOut[0]});
    for (k = 0; k < 3000 && multiReference !== 12'h0FA; k++) begin
      @(posedge clock);
    end
    cyc(6);
    chk("multiReference", 12'h0FA, multiReference);
    chk("phaseDriveOe", 12'h000, phaseDriveOe);
    chk("driverEnableOut", 12'h000, driverEnableOut);
    chk("faultIndicatorPin", 12'h001, faultIndicatorPin);
    // ----------------------------------------
    // Loop pass-through, phase current, low voltage on single
    // ----------------------------------------
    rst();
    @(posedge clock);
    loopPwm <= 7'h55;
    loopDriverEnable <= 2'h1;
    railGood <= 2'h2;
    loadReportPin <= 12'h4D7;
    cyc(3);
    chk("phaseDriveOut", 12'h005, {8'h00, phaseDriveOut[3:0]});
    chk("phaseDriveOe", 12'h04F, phaseDriveOe);
    chk("driverEnableOut", 12'h001, driverEnableOut);
    chk("railReadyFlag", 12'h002, railReadyFlag);
    chk("maxCurrentReached", 12'h000, maxCurrentReached);
    @(posedge clock);
    loopPwm <= 7'h7F;
    loopDriverEnable <= 2'h3;
    railGood <= 2'h3;
    loadReportPin <= 12'h4D8;
    phaseCurrentOver <= 7'h01;
    cyc(5);
    chk("maxCurrentReached", 12'h001, maxCurrentReached);
    chk("lowSideOn", 12'h001, lowSideOn[0]);
    @(posedge clock);
    phaseCurrentOver <= 7'h00;
    cyc(5);
    chk("phaseDriveOut", 12'h001, phaseDriveOut[0]);
    ramp(1, 12'h258);
    @(posedge clock);
    sOff <= 12'hE6F;
    cyc(100);
    chk("faultKind", `RFP_FK_NONE, faultKind);
    cyc(420);
    chk("faultKind", `RFP_FK_UV, faultKind);
    chk("faultSection", `RFP_SEC_SINGLE, faultSection);
    chk("railReadyFlag", 12'h001, railReadyFlag);
    chk("driveOff", 12'h000, {phaseDriveOe, driverEnableOut, faultIndicatorPin});
    // ----------------------------------------
    // Total overcurrent by state and phase count
    // ----------------------------------------
    for (k = 0; k < 5; k++) begin
      rst();
      @(posedge clock);
      powerStateCommand <= tPs[k];
      phaseCount <= tN[k];
      totalLimitPin <= tThr[k] - 12'h00A;
      cyc(6);
      chk("activePhases", tPs[k] == 2'h0 ? tN[k] : 3'h2, activePhases);
      chk("faultKind", `RFP_FK_NONE, faultKind);
      @(posedge clock);
      totalLimitPin <= tThr[k] + 12'h00A;
      cyc(6);
      chk("faultKind", `RFP_FK_OC, faultKind);
      chk("driveOff", 12'h000, {phaseDriveOe, driverEnableOut});
      chk("railReadyFlag", 12'h002, railReadyFlag);
    end
    // ----------------------------------------
    // Single total current, slow ramp, ramp-time limit
    // ----------------------------------------
    rst();
    @(posedge clock);
    singleLimitPin <= 12'h60F;
    cyc(6);
    chk("faultKind", `RFP_FK_OC, faultKind);
    chk("faultSection", `RFP_SEC_SINGLE, faultSection);
    chk("railReadyFlag", 12'h001, railReadyFlag);
    rst();
    @(posedge clock);
    rampFast <= 1'b0;
    voltCmdValid <= 2'h2;
    voltCmdCode <= 12'h004;
    @(posedge clock);
    voltCmdValid <= 2'h0;
    cyc(75);
    chk("singleReference", 12'h001, singleReference);
    for (k = 0; k < 400 && singleReference !== 12'h004; k++) begin
      @(posedge clock);
    end
    @(posedge clock);
    offsetCommanded <= 1'b1;
    sOff <= 12'h7D0;
    cyc(5);
    chk("faultKind", `RFP_FK_NONE, faultKind);
    @(posedge clock);
    offsetCommanded <= 1'b0;
    cyc(5);
    chk("faultKind", `RFP_FK_OV, faultKind);
    chk("faultSection", `RFP_SEC_SINGLE, faultSection);
    chk("otherSection", 12'h000, {phaseDriveOe[5:0], driverEnableOut[0]});
    finish_test();
  end
endmodule // test_rail_fault_protection
